// File: tla_pkg.sv
// Constants and types shared by the temperature limit alarm logic
`default_nettype none
package tla_pkg;
    // Register byte offsets
    localparam logic [7:0] TLA_OFF_CFG = 8'h00;
    localparam logic [7:0] TLA_OFF_CHEN = 8'h04;
    localparam logic [7:0] TLA_OFF_FILT = 8'h08;
    localparam logic [7:0] TLA_OFF_HYST = 8'h0C;
    localparam logic [7:0] TLA_OFF_MASK1 = 8'h10;
    localparam logic [7:0] TLA_OFF_MASK2 = 8'h14;
    localparam logic [7:0] TLA_OFF_MASK3 = 8'h18;
    localparam logic [7:0] TLA_OFF_LIM_BASE = 8'h20;
    localparam logic [7:0] TLA_OFF_LIM_LAST = 8'h38;
    localparam logic [7:0] TLA_OFF_STATUS = 8'h40;
    localparam logic [7:0] TLA_OFF_TS_BASE = 8'h50;
    localparam logic [7:0] TLA_OFF_TS_LAST = 8'h60;
    localparam logic [7:0] TLA_OFF_TU_BASE = 8'h70;
    localparam logic [7:0] TLA_OFF_TU_LAST = 8'h80;
    // Channel and limit slot counts
    localparam int TLA_NCH = 5;
    localparam int TLA_NLIM = 7;
    // Reset values
    localparam logic [1:0] TLA_CFG_RST = 2'h3;
    localparam logic [4:0] TLA_CHEN_RST = 5'h1F;
    localparam logic [3:0] TLA_FILT_RST = 4'hF;
    localparam logic [7:0] TLA_HYST_RST = 8'h05;
    localparam logic [4:0] TLA_MASK1_RST = 5'h19;
    localparam logic [4:0] TLA_MASK2_RST = 5'h00;
    localparam logic [4:0] TLA_MASK3_RST = 5'h07;
    localparam logic [7:0] TLA_LIM_PRI_RST = 8'h6E;
    localparam logic [7:0] TLA_LIM_SEC_RST = 8'h55;
    // Fault queue length in conversions
    localparam int TLA_FQ_COUNT = 3;
    // Clamp points of the raw value, step 1/32 degree
    localparam logic signed [15:0] TLA_SMIN = 16'shF000;
    localparam logic signed [15:0] TLA_SMAX = 16'sh0FFF;
    localparam logic signed [15:0] TLA_UMAX = 16'sh1FFF;
    localparam logic [15:0] TLA_WORD_UMAX_COARSE = 16'hFFE0;
    localparam logic [15:0] TLA_WORD_MINUS_FINE = 16'hFFF8;
    // Alarm hysteresis state
    typedef enum logic [1:0] {
        TLA_ST_CLR = 2'b01,
        TLA_ST_SET = 2'b10
    } tla_alarm_st_t;
endpackage
`default_nettype wire

// File: tla_fmt.sv
// Left-justified temperature word formatter with clamping
`timescale 1ns/1ps
`default_nettype none
module tla_fmt
(
    // Raw result, 1/32 degree step
    input wire logic signed [15:0] raw,
    // Format selection
    input wire logic uns,
    input wire logic fine,
    // Formatted word
    output logic [15:0] word
);
    wire logic signed [15:0] hi_lim;
    wire logic signed [15:0] lo_lim;
    wire logic signed [15:0] clamped;
    wire logic [15:0] shifted;

    assign hi_lim = uns ? tla_pkg::TLA_UMAX : tla_pkg::TLA_SMAX;
    assign lo_lim = uns ? 16'sh0000 : tla_pkg::TLA_SMIN;
    // Saturate, never wrap
    assign clamped = (raw > hi_lim) ? hi_lim : ((raw < lo_lim) ? lo_lim : raw);
    // Unsigned upper byte is a plain degree count
    assign shifted = {clamped[12:0], 3'b000};
    // Fine step at bit 3, coarse step at bit 5
    assign word = fine ? shifted : {shifted[15:5], 5'b00000};
    // No clock here: the formatter checks sit in the parent's clock domain
endmodule // tla_fmt
`default_nettype wire

// File: tla_cmp.sv
// One limit comparator with hysteresis and optional fault queue
`timescale 1ns/1ps
`default_nettype none
module tla_cmp
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Conversion step
    input wire logic step,
    input wire logic fq_en,
    input wire logic signed [15:0] temp,
    // Settings
    input wire logic [7:0] limit,
    input wire logic [7:0] hyst,
    // Result
    output logic flag
);
    localparam logic [1:0] FQ_LAST = 2'(tla_pkg::TLA_FQ_COUNT - 1);
    tla_pkg::tla_alarm_st_t st_q;
    tla_pkg::tla_alarm_st_t st_d;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    wire logic signed [16:0] t17;
    wire logic signed [16:0] hi17;
    wire logic signed [8:0] lo9;
    wire logic signed [16:0] lo17;
    wire logic over;
    wire logic under;
    wire logic cond;
    wire logic done;

    assign t17 = {temp[15], temp};
    assign hi17 = {4'h0, limit, 5'b00000};
    assign lo9 = $signed({1'b0, limit}) - $signed({1'b0, hyst});
    assign lo17 = {{3{lo9[8]}}, lo9, 5'b00000};
    assign over = t17 > hi17;
    // Release only below limit minus hysteresis
    assign under = t17 < lo17;
    assign cond = (st_q == tla_pkg::TLA_ST_SET) ? under : over;
    assign done = !fq_en || (cnt_q == FQ_LAST);

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        if (step)
        begin
            case (st_q)
                tla_pkg::TLA_ST_CLR, tla_pkg::TLA_ST_SET:
                begin
                    if (!cond)
                        cnt_d = 2'b00;
                    else if (done)
                    begin
                        cnt_d = 2'b00;
                        st_d = (st_q == tla_pkg::TLA_ST_SET) ? tla_pkg::TLA_ST_CLR : tla_pkg::TLA_ST_SET;
                    end
                    else
                        cnt_d = cnt_q + 2'b01;
                end
                default:
                begin
                    st_d = tla_pkg::TLA_ST_CLR;
                    cnt_d = 2'b00;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            st_q <= tla_pkg::TLA_ST_CLR;
            cnt_q <= 2'b00;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    assign flag = (st_q == tla_pkg::TLA_ST_SET);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_set_direct;
        (step && over && !flag && !fq_en) |=> flag;
    endproperty
    a_set_direct: assert property (p_set_direct) else $error("flag not set on over-limit");

    property p_hold;
        (flag && !(step && under)) |=> flag;
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped above release point");

    property p_fq_set;
        (fq_en && !flag && step && over && cnt_q != FQ_LAST) |=> !flag;
    endproperty
    a_fq_set: assert property (p_fq_set) else $error("fault queue set too early");

    property p_skip;
        !step |=> $stable(flag);
    endproperty
    a_skip: assert property (p_skip) else $error("flag moved without conversion");

    c_fq_trip: cover property (fq_en && step && over && cnt_q == FQ_LAST && !flag);
endmodule // tla_cmp
`default_nettype wire

// File: tla_alarm_logic.sv
// Limit comparison, status, masks and alarm outputs behind an APB slave
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Filtered remote 1/2 use 1/32 degree step
// - Filtered step sits at word bit three
// - Local channel signed coarse only
// - Unsigned coarse saturates at FFE0h
// - Unsigned upper byte counts whole degrees
// - Alarm pins only pull low
// - Local limit compare, default 85, readable
// - Masks gate outputs, status unmasked
// - Remote 1 primary 110, secondary 85
// - Remote 2 same as remote 1
// - Remote 3 single limit, default 85
// - Remote 4 single limit, default 85
// - Output 1 primary, outputs 2/3 secondary
// - Over limit sets flag and alarm
// - Release below limit minus hysteresis
// - Fault queue needs three consecutive results
// - Config bits 0/1 enable queues, default on
// - Filtered value used for comparison
// - Clamp at full scale, zero unused bits
module tla_alarm_logic
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Conversion results, 1/32 degree step
    input wire logic conv_valid,
    input wire logic [2:0] conv_chan,
    input wire logic signed [15:0] conv_temp,
    // Filter selection to the front end
    output logic [3:0] filt_sel,
    // Open-drain alarm pins
    output logic alarm_out_1_n_o,
    output logic alarm_out_1_n_oe,
    output logic alarm_out_2_n_o,
    output logic alarm_out_2_n_oe,
    output logic alarm_out_3_n_o,
    output logic alarm_out_3_n_oe
);
    logic [1:0] cfg_q;
    logic [4:0] chen_q;
    logic [3:0] filt_q;
    logic [7:0] hyst_q;
    logic [4:0] mask_q [3];
    logic [7:0] lim_q [tla_pkg::TLA_NLIM];
    logic signed [15:0] temp_q [tla_pkg::TLA_NCH];
    logic [2:0] oe_q;
    logic [2:0] lvl_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    wire logic setup;
    wire logic wr_en;
    wire logic hit;
    wire logic lim_hit;
    wire logic ts_hit;
    wire logic tu_hit;
    wire logic [2:0] lim_idx;
    wire logic [2:0] t_idx;
    wire logic [2:0] t_sel;
    wire logic [4:0] ch_fine;
    wire logic [6:0] fl;
    wire logic [4:0] st2;
    wire logic [4:0] st3;
    wire logic [4:0] st4;
    wire logic [2:0] act;
    wire logic [15:0] t_word;
    wire logic [31:0] rd_word;

    // Map a limit slot to its channel
    function automatic logic [2:0] slot_chan(input int k);
        case (k)
            0: slot_chan = 3'd0;
            1, 2: slot_chan = 3'd1;
            3, 4: slot_chan = 3'd2;
            5: slot_chan = 3'd3;
            default: slot_chan = 3'd4;
        endcase
    endfunction

    // Reset value of each limit slot
    function automatic logic [7:0] slot_rst(input int k);
        if (k == 1 || k == 3)
            slot_rst = tla_pkg::TLA_LIM_PRI_RST;
        else
            slot_rst = tla_pkg::TLA_LIM_SEC_RST;
    endfunction

    // Word-aligned range test
    function automatic logic in_rng(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        in_rng = (a >= lo) && (a <= hi) && (a[1:0] == 2'b00);
    endfunction

    // Address decode
    assign setup = psel && !penable;
    assign lim_hit = in_rng(paddr, tla_pkg::TLA_OFF_LIM_BASE, tla_pkg::TLA_OFF_LIM_LAST);
    assign ts_hit = in_rng(paddr, tla_pkg::TLA_OFF_TS_BASE, tla_pkg::TLA_OFF_TS_LAST);
    // No unsigned form exists for the local channel
    assign tu_hit = in_rng(paddr, tla_pkg::TLA_OFF_TU_BASE + 8'h04, tla_pkg::TLA_OFF_TU_LAST);
    assign lim_idx = 3'((paddr - tla_pkg::TLA_OFF_LIM_BASE) >> 2);
    assign t_idx = ts_hit ? 3'((paddr - tla_pkg::TLA_OFF_TS_BASE) >> 2)
                          : 3'((paddr - tla_pkg::TLA_OFF_TU_BASE) >> 2);
    assign t_sel = (ts_hit || tu_hit) ? t_idx : 3'd0;
    assign hit = (paddr == tla_pkg::TLA_OFF_CFG) || (paddr == tla_pkg::TLA_OFF_CHEN)
               || (paddr == tla_pkg::TLA_OFF_FILT) || (paddr == tla_pkg::TLA_OFF_HYST)
               || (paddr == tla_pkg::TLA_OFF_MASK1) || (paddr == tla_pkg::TLA_OFF_MASK2)
               || (paddr == tla_pkg::TLA_OFF_MASK3) || (paddr == tla_pkg::TLA_OFF_STATUS)
               || lim_hit || ts_hit || tu_hit;
    // Temperature and status registers ignore writes
    assign wr_en = psel && penable && pready_q && pwrite && hit && !ts_hit && !tu_hit
                 && (paddr != tla_pkg::TLA_OFF_STATUS);

    // Filter on when either filter setting bit is set
    assign ch_fine = {2'b00, |filt_q[3:2], |filt_q[1:0], 1'b0};

    tla_fmt u_fmt
    (
        .raw(temp_q[t_sel]),
        .uns(tu_hit),
        .fine(ch_fine[t_sel]),
        .word(t_word)
    );

    // Status bit order: local, remote 1..4
    assign st2 = {fl[6], fl[5], fl[3], fl[1], fl[0]};
    assign st3 = {fl[6], fl[5], fl[4], fl[2], fl[0]};
    assign st4 = st3;
    assign act[0] = |(st2 & ~mask_q[0]);
    assign act[1] = |(st3 & ~mask_q[1]);
    assign act[2] = |(st4 & ~mask_q[2]);

    assign rd_word = (paddr == tla_pkg::TLA_OFF_CFG) ? {30'h0, cfg_q}
                   : (paddr == tla_pkg::TLA_OFF_CHEN) ? {27'h0, chen_q}
                   : (paddr == tla_pkg::TLA_OFF_FILT) ? {28'h0, filt_q}
                   : (paddr == tla_pkg::TLA_OFF_HYST) ? {24'h0, hyst_q}
                   : (paddr == tla_pkg::TLA_OFF_MASK1) ? {27'h0, mask_q[0]}
                   : (paddr == tla_pkg::TLA_OFF_MASK2) ? {27'h0, mask_q[1]}
                   : (paddr == tla_pkg::TLA_OFF_MASK3) ? {27'h0, mask_q[2]}
                   : (paddr == tla_pkg::TLA_OFF_STATUS) ? {17'h0, st4, st3, st2}
                   : lim_hit ? {24'h0, lim_q[lim_idx]}
                   : (ts_hit || tu_hit) ? {16'h0, t_word}
                   : 32'h0000_0000;

    // Answer one cycle after setup; read data frozen at setup
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= setup;
            pslverr_q <= setup && !hit;
            prdata_q <= (setup && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cfg_q <= tla_pkg::TLA_CFG_RST;
            chen_q <= tla_pkg::TLA_CHEN_RST;
            filt_q <= tla_pkg::TLA_FILT_RST;
            hyst_q <= tla_pkg::TLA_HYST_RST;
            mask_q[0] <= tla_pkg::TLA_MASK1_RST;
            mask_q[1] <= tla_pkg::TLA_MASK2_RST;
            mask_q[2] <= tla_pkg::TLA_MASK3_RST;
        end
        else if (wr_en)
        begin
            case (paddr)
                tla_pkg::TLA_OFF_CFG: cfg_q <= pwdata[1:0];
                tla_pkg::TLA_OFF_CHEN: chen_q <= pwdata[4:0];
                tla_pkg::TLA_OFF_FILT: filt_q <= pwdata[3:0];
                tla_pkg::TLA_OFF_HYST: hyst_q <= pwdata[7:0];
                tla_pkg::TLA_OFF_MASK1: mask_q[0] <= pwdata[4:0];
                tla_pkg::TLA_OFF_MASK2: mask_q[1] <= pwdata[4:0];
                tla_pkg::TLA_OFF_MASK3: mask_q[2] <= pwdata[4:0];
                default: ;
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < tla_pkg::TLA_NCH; g++)
        begin : g_ch
            // Readings start at zero until the first conversion
            always_ff @(posedge clk_sys)
            begin
                if (sys_rst)
                    temp_q[g] <= 16'sh0000;
                else if (conv_valid && conv_chan == 3'(g) && chen_q[g])
                    temp_q[g] <= conv_temp;
            end
        end

        for (g = 0; g < tla_pkg::TLA_NLIM; g++)
        begin : g_lim
            localparam logic [2:0] CH = slot_chan(g);
            wire logic step;
            wire logic fq;
            wire logic signed [15:0] cval;

            always_ff @(posedge clk_sys)
            begin
                if (sys_rst)
                    lim_q[g] <= slot_rst(g);
                else if (wr_en && lim_hit && lim_idx == 3'(g))
                    lim_q[g] <= pwdata[7:0];
            end

            // Disabled channels keep their last outcome
            assign step = conv_valid && conv_chan == CH && chen_q[CH];
            assign fq = (g == 5) ? cfg_q[0] : ((g == 6) ? cfg_q[1] : 1'b0);
            // Unfiltered channels compare at 0.125 degree resolution
            assign cval = ch_fine[CH] ? conv_temp : {conv_temp[15:2], 2'b00};

            tla_cmp u_cmp
            (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .step(step),
                .fq_en(fq),
                .temp(cval),
                .limit(lim_q[g]),
                .hyst(hyst_q),
                .flag(fl[g])
            );
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            oe_q <= 3'b000;
            lvl_q <= 3'b000;
        end
        else
        begin
            oe_q <= act;
            lvl_q <= 3'b000;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign filt_sel = filt_q;
    // Drive low only; the high level comes from the pull-up
    assign alarm_out_1_n_o = lvl_q[0];
    assign alarm_out_2_n_o = lvl_q[1];
    assign alarm_out_3_n_o = lvl_q[2];
    assign alarm_out_1_n_oe = oe_q[0];
    assign alarm_out_2_n_oe = oe_q[1];
    assign alarm_out_3_n_oe = oe_q[2];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_drive_low;
        (alarm_out_1_n_o == 1'b0) && (alarm_out_2_n_o == 1'b0) && (alarm_out_3_n_o == 1'b0);
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("alarm pin driven high");

    property p_mask_gate;
        ##1 alarm_out_2_n_oe == $past(|(st3 & ~mask_q[1]));
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("alarm 2 not OR of unmasked flags");

    property p_out1_primary;
        (fl[1] && !mask_q[0][1]) |=> alarm_out_1_n_oe;
    endproperty
    a_out1_primary: assert property (p_out1_primary) else $error("alarm 1 ignores primary flag");

    property p_lim_reset;
        $past(sys_rst) |-> (lim_q[0] == tla_pkg::TLA_LIM_SEC_RST) && (lim_q[1] == tla_pkg::TLA_LIM_PRI_RST);
    endproperty
    a_lim_reset: assert property (@(posedge clk_sys) p_lim_reset) else $error("limit reset value wrong");

    property p_local_uns;
        (setup && paddr == tla_pkg::TLA_OFF_TU_BASE) |=> pslverr;
    endproperty
    a_local_uns: assert property (p_local_uns) else $error("local unsigned read not refused");

    property p_status_read;
        (setup && !pwrite && paddr == tla_pkg::TLA_OFF_STATUS) |=> (prdata[4:0] == $past(st2)) && pready;
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    // Unused low bits read zero in coarse form
    property p_fmt_low_zero;
        !ch_fine[t_sel] |-> (t_word[4:0] == 5'b00000);
    endproperty
    a_fmt_low_zero: assert property (p_fmt_low_zero) else $error("coarse low bits not zero");

    property p_fmt_uns_sat;
        (tu_hit && !ch_fine[t_sel] && temp_q[t_sel] > tla_pkg::TLA_UMAX)
            |-> (t_word == tla_pkg::TLA_WORD_UMAX_COARSE);
    endproperty
    a_fmt_uns_sat: assert property (p_fmt_uns_sat) else $error("unsigned saturation wrong");

    property p_fmt_fine_neg;
        (!tu_hit && ch_fine[t_sel] && temp_q[t_sel] == -16'sd1) |-> (t_word == tla_pkg::TLA_WORD_MINUS_FINE);
    endproperty
    a_fmt_fine_neg: assert property (p_fmt_fine_neg) else $error("fine minus one step wrong");

    c_alarm1: cover property ($rose(alarm_out_1_n_oe));
    c_alarm3_release: cover property ($fell(alarm_out_3_n_oe));
    c_temp_read: cover property (setup && !pwrite && tu_hit ##1 pready);
    c_write: cover property (psel && penable && pwrite && pready && hit);
endmodule // tla_alarm_logic
`default_nettype wire

// File: tla_sys_model.sv
// Far-side model: pull-ups on the three open-drain alarm pins
`timescale 1ns/1ps
`default_nettype none
module tla_sys_model
(
    // Open-drain drives from the device, bit 0 is output 1
    input wire logic [2:0] drv_o,
    input wire logic [2:0] drv_oe,
    // Resolved pin levels
    output logic [2:0] pin_lvl
);
    // A high level comes from the external pull-up or from an enabled drive of one
    assign pin_lvl = (drv_oe & drv_o) | ~drv_oe;
endmodule // tla_sys_model
`default_nettype wire

// File: testbench.sv
// Table-driven bench for the temperature limit alarm logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct {logic wr; logic [2:0] ch; logic [15:0] tp; logic [7:0] ad; logic [15:0] dv; logic er;
        logic [2:0] pn;} tla_row_t;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic conv_valid = 1'b0;
    logic [2:0] conv_chan = 3'h0;
    logic signed [15:0] conv_temp = 16'sh0000;
    logic [2:0] a_o;
    logic [2:0] a_oe;
    logic [2:0] pins;
    logic [3:0] fsel;
    logic [31:0] rd;
    logic er;
    int err_count = 0;
    int total_checks = 0;
    // Chan 7 rows send a conversion the device must drop
    tla_row_t rows [50] = '{
        '{1'b0, 3'h7, 16'h7FFF, 8'h00, 16'h0003, 1'b0, 3'h7},
        '{1'b0, 3'h7, 16'h7FFF, 8'h04, 16'h001F, 1'b0, 3'h7},
        '{1'b0, 3'h7, 16'h7FFF, 8'h08, 16'h000F, 1'b0, 3'h7},
        '{1'b0, 3'h7, 16'h7FFF, 8'h0C, 16'h0005, 1'b0, 3'h7},
        '{1'b0, 3'h7, 16'h7FFF, 8'h10, 16'h0019, 1'b0, 3'h7},
        '{1'b0, 3'h7, 16'h7FFF, 8'h14, 16'h0000, 1'b0, 3'h7},
        '{1'b0, 3'h7, 16'h7FFF, 8'h18, 16'h0007, 1'b0, 3'h7},
        '{1'b0, 3'h7, 16'h7FFF, 8'h20, 16'h0055, 1'b0, 3'h7},
        '{1'b0, 3'h7, 16'h7FFF, 8'h24, 16'h006E, 1'b0, 3'h7},
        '{1'b0, 3'h7, 16'h7FFF, 8'h28, 16'h0055, 1'b0, 3'h7},
        '{1'b0, 3'h7, 16'h7FFF, 8'h2C, 16'h006E, 1'b0, 3'h7},
        '{1'b0, 3'h7, 16'h7FFF, 8'h30, 16'h0055, 1'b0, 3'h7},
        '{1'b0, 3'h7, 16'h7FFF, 8'h34, 16'h0055, 1'b0, 3'h7},
        '{1'b0, 3'h7, 16'h7FFF, 8'h38, 16'h0055, 1'b0, 3'h7},
        '{1'b0, 3'h7, 16'h7FFF, 8'h40, 16'h0000, 1'b0, 3'h7},
        '{1'b0, 3'h7, 16'h7FFF, 8'h50, 16'h0000, 1'b0, 3'h7},
        '{1'b0, 3'h7, 16'h7FFF, 8'h44, 16'h0000, 1'b1, 3'h7},
        '{1'b0, 3'h0, 16'h0020, 8'h50, 16'h0100, 1'b0, 3'h7},
        '{1'b0, 3'h0, 16'hFFFC, 8'h50, 16'hFFE0, 1'b0, 3'h7},
        '{1'b0, 3'h7, 16'h0000, 8'h70, 16'h0000, 1'b1, 3'h7},
        '{1'b0, 3'h1, 16'h0001, 8'h54, 16'h0008, 1'b0, 3'h7},
        '{1'b0, 3'h7, 16'h0000, 8'h74, 16'h0008, 1'b0, 3'h7},
        '{1'b0, 3'h1, 16'hFFFF, 8'h54, 16'hFFF8, 1'b0, 3'h7},
        '{1'b0, 3'h3, 16'h0004, 8'h7C, 16'h0020, 1'b0, 3'h7},
        '{1'b0, 3'h3, 16'h1920, 8'h7C, 16'hC900, 1'b0, 3'h7},
        '{1'b0, 3'h3, 16'h0005, 8'h5C, 16'h0020, 1'b0, 3'h7},
        '{1'b0, 3'h4, 16'h2580, 8'h80, 16'hFFE0, 1'b0, 3'h7},
        '{1'b0, 3'h7, 16'h0000, 8'h60, 16'h7FE0, 1'b0, 3'h7},
        '{1'b0, 3'h0, 16'h0AA0, 8'h40, 16'h0000, 1'b0, 3'h7},
        '{1'b0, 3'h0, 16'h0AA4, 8'h40, 16'h0421, 1'b0, 3'h5},
        '{1'b0, 3'h0, 16'h0A00, 8'h40, 16'h0421, 1'b0, 3'h5},
        '{1'b0, 3'h0, 16'h09FF, 8'h40, 16'h0000, 1'b0, 3'h7},
        '{1'b0, 3'h1, 16'h0C80, 8'h40, 16'h0840, 1'b0, 3'h5},
        '{1'b0, 3'h1, 16'h0DC1, 8'h40, 16'h0842, 1'b0, 3'h4},
        '{1'b0, 3'h2, 16'h0DC0, 8'h40, 16'h18C2, 1'b0, 3'h4},
        '{1'b0, 3'h1, 16'h0000, 8'h40, 16'h1080, 1'b0, 3'h5},
        '{1'b0, 3'h2, 16'h0000, 8'h40, 16'h0000, 1'b0, 3'h7},
        '{1'b0, 3'h3, 16'h0B40, 8'h40, 16'h0000, 1'b0, 3'h7},
        '{1'b0, 3'h3, 16'h0B40, 8'h40, 16'h0000, 1'b0, 3'h7},
        '{1'b0, 3'h3, 16'h0B40, 8'h40, 16'h2108, 1'b0, 3'h1},
        '{1'b0, 3'h3, 16'h0000, 8'h40, 16'h2108, 1'b0, 3'h1},
        '{1'b0, 3'h3, 16'h0000, 8'h40, 16'h2108, 1'b0, 3'h1},
        '{1'b0, 3'h3, 16'h0000, 8'h40, 16'h0000, 1'b0, 3'h7},
        '{1'b1, 3'h7, 16'h0000, 8'h00, 16'h0001, 1'b0, 3'h7},
        '{1'b0, 3'h4, 16'h0B40, 8'h40, 16'h4210, 1'b0, 3'h1},
        '{1'b1, 3'h7, 16'h0000, 8'h14, 16'h001F, 1'b0, 3'h3},
        '{1'b0, 3'h7, 16'h0000, 8'h40, 16'h4210, 1'b0, 3'h3},
        '{1'b1, 3'h7, 16'h0000, 8'h04, 16'h001E, 1'b0, 3'h3},
        '{1'b0, 3'h0, 16'h0F00, 8'h40, 16'h4210, 1'b0, 3'h3},
        '{1'b0, 3'h7, 16'h0000, 8'h50, 16'h4FE0, 1'b0, 3'h3}
    };

    tla_alarm_logic dut
    (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_temp(conv_temp), .filt_sel(fsel),
        .alarm_out_1_n_o(a_o[0]), .alarm_out_1_n_oe(a_oe[0]), .alarm_out_2_n_o(a_o[1]),
        .alarm_out_2_n_oe(a_oe[1]), .alarm_out_3_n_o(a_o[2]), .alarm_out_3_n_oe(a_oe[2])
    );
    tla_sys_model far_side
    (
        .drv_o(a_o),
        .drv_oe(a_oe),
        .pin_lvl(pins)
    );

    always #50 clk_sys = ~clk_sys;

    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Entered just after a rising edge; ready and data are taken at the rising edge itself
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                       output logic [31:0] rdv, output logic erv);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 16)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (pready !== 1'b1)
        begin
            err_count++;
            tally_and_finish();
        end
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Alarm pins follow a register write one edge later
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic conv(input logic [2:0] ch, input logic [15:0] tp);
        conv_chan <= ch;
        conv_temp <= $signed(tp);
        conv_valid <= 1'b1;
        @(posedge clk_sys);
        conv_valid <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    initial
    begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        foreach (rows[i])
        begin
            conv(rows[i].ch, rows[i].tp);
            apb(rows[i].wr, rows[i].ad, {16'h0000, rows[i].dv}, rd, er);
            if (!rows[i].wr)
            begin
                chk(rd, {16'h0000, rows[i].dv});
            end
            chk({31'h0, er}, {31'h0, rows[i].er});
            chk({29'h0, pins}, {29'h0, rows[i].pn});
        end
        $display("Table test done");
        // Second reset with alarm 3 still active
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({29'h0, pins}, 32'h0000_0007);
        chk({28'h0, fsel}, 32'h0000_000F);
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        apb(1'b0, 8'h40, 32'h0, rd, er);
        chk(rd, 32'h0);
        apb(1'b0, 8'h04, 32'h0, rd, er);
        chk(rd, 32'h0000_001F);
        apb(1'b0, 8'h14, 32'h0, rd, er);
        chk(rd, 32'h0);
        $display("Reset test done");
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
